// *** src/fde_core.sv ***
// float divide / exponential decoder and executor
//
// Contract
// - divide converts source, divides destination, writes quotient back.
// - divide-by-zero flag only for finite over zero; else cleared.
// - operand-error flag set for zero over zero, infinity over infinity.
// - execute only when operation word bits 11:9 match own identity.
// - register-or-memory bit 0 is register source, 1 is memory source.
// - register source: source specifier names the source float register.
// - memory source: specifier is the source format code, 000 to 110.
// - effective address split into mode and register; modes checked.
// - data register direct only for byte, word, long, single; never An.
// - destination field selects the float register taking the result.
// - exponential converts source, writes e raised to it to destination; only NaN, zero and infinity sources are written, finite ones flag unsupported.
// - exponential accepts all seven source formats; packed sources flag unsupported with no write.
//
// Design decisions made here: the address map and strobed register access.
`timescale 1ns/1ns
module fde_core #(
  parameter logic [2:0] OWN_ID_RESET = 3'h1
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [7:0] addr,
  input wire logic [31:0] wdata,
  input wire logic wr_en,
  input wire logic rd_en,
  output logic [31:0] rdata,
  output logic irq
);
  logic [79:0] fpr [8];
  fde_pkg::fde_state_t state;
  logic [15:0] op_word;
  logic [2:0] own_id;
  logic [79:0] src_buf;
  logic [7:0] exc;
  logic [fde_pkg::INT_W-1:0] int_status;
  logic [fde_pkg::INT_W-1:0] int_mask;
  logic [2:0] reg_sel;
  logic [64:0] rem;
  logic [63:0] divisor;
  logic [64:0] quo;
  logic [6:0] cnt;
  logic q_sign;
  logic signed [17:0] q_exp;
  logic [2:0] q_dst;

  function automatic logic [79:0] int_to_ext(input logic [31:0] v);
    logic [31:0] mag;
    logic [63:0] m;
    logic [14:0] e;
    mag = v[31] ? (~v + 32'h0000_0001) : v;
    m = {mag, 32'h0000_0000};
    e = fde_pkg::INT_EXP_TOP;
    for (int i = 0; i < 32; i++) begin
      if (!m[63] && m != 64'h0000_0000_0000_0000) begin
        m = m << 1;
        e = e - 15'h0001;
      end
    end
    if (mag == 32'h0000_0000) begin
      return {1'b0, 15'h0000, 64'h0000_0000_0000_0000};
    end
    return {v[31], e, m};
  endfunction

  // denormal single/double inputs are flushed to signed zero
  function automatic logic [79:0] to_ext(input logic [2:0] fmt,
                                         input logic [79:0] s);
    logic [79:0] r;
    r = s;
    case (fmt)
      fde_pkg::FMT_LONG: r = int_to_ext(s[31:0]);
      fde_pkg::FMT_WORD: r = int_to_ext({{16{s[15]}}, s[15:0]});
      fde_pkg::FMT_BYTE: r = int_to_ext({{24{s[7]}}, s[7:0]});
      fde_pkg::FMT_SINGLE: begin
        if (s[30:23] == 8'hff) begin
          r = {s[31], fde_pkg::EXP_MAX, 1'b1, s[22:0], 40'h00_0000_0000};
        end else if (s[30:23] == 8'h00) begin
          r = {s[31], 79'h0};
        end else begin
          r = {s[31], 15'({7'h00, s[30:23]}) + fde_pkg::SGL_ADJ,
               1'b1, s[22:0], 40'h00_0000_0000};
        end
      end
      fde_pkg::FMT_DOUBLE: begin
        if (s[62:52] == 11'h7ff) begin
          r = {s[63], fde_pkg::EXP_MAX, 1'b1, s[51:0], 11'h000};
        end else if (s[62:52] == 11'h000) begin
          r = {s[63], 79'h0};
        end else begin
          r = {s[63], 15'({4'h0, s[62:52]}) + fde_pkg::DBL_ADJ,
               1'b1, s[51:0], 11'h000};
        end
      end
      default: r = s;
    endcase
    return r;
  endfunction

  function automatic fde_pkg::fde_class_t classify(input logic [79:0] x);
    if (x[78:64] == fde_pkg::EXP_MAX) begin
      return (x[62:0] == 63'h0) ? fde_pkg::CLS_INF : fde_pkg::CLS_NAN;
    end
    if (x[78:64] == 15'h0000 && x[63:0] == 64'h0000_0000_0000_0000) begin
      return fde_pkg::CLS_ZERO;
    end
    return fde_pkg::CLS_FIN;
  endfunction

  // register bus decode
  wire idle = (state == fde_pkg::ST_IDLE);
  wire wr_ctrl = wr_en && addr == fde_pkg::ADDR_CTRL;
  wire wr_op = wr_en && addr == fde_pkg::ADDR_OPWORD && idle;
  wire start = wr_en && addr == fde_pkg::ADDR_EXTWORD && idle;
  wire wr_src_lo = wr_en && addr == fde_pkg::ADDR_SRC_LO;
  wire wr_src_mid = wr_en && addr == fde_pkg::ADDR_SRC_MID;
  wire wr_src_hi = wr_en && addr == fde_pkg::ADDR_SRC_HI;
  wire wr_int_st = wr_en && addr == fde_pkg::ADDR_INT_STATUS;
  wire wr_int_mask = wr_en && addr == fde_pkg::ADDR_INT_MASK;
  wire wr_reg_sel = wr_en && addr == fde_pkg::ADDR_REG_SEL;
  wire wr_reg_lo = wr_en && addr == fde_pkg::ADDR_REG_LO;
  wire wr_reg_mid = wr_en && addr == fde_pkg::ADDR_REG_MID;
  wire wr_reg_hi = wr_en && addr == fde_pkg::ADDR_REG_HI;

  // instruction decode, extension word arrives on the data bus
  wire [15:0] ext = wdata[15:0];
  wire ext_rm = ext[fde_pkg::EXT_RM_BIT];
  wire [2:0] ext_spec = ext[12:10];
  wire [2:0] ext_dst = ext[9:7];
  wire [6:0] ext_opm = ext[6:0];
  wire ext_base_ok = !ext[fde_pkg::EXT_TOP_BIT] && !ext[fde_pkg::EXT_ZERO_BIT];
  wire is_div = ext_base_ok && ext_opm == fde_pkg::OPMODE_DIVIDE;
  wire is_exp = ext_base_ok && ext_opm == fde_pkg::OPMODE_EXP;
  wire id_ok = op_word[fde_pkg::OP_ID_HI:fde_pkg::OP_ID_LO] == own_id
    && op_word[15:12] == fde_pkg::OP_PREFIX
    && op_word[8:6] == 3'h0;
  wire [2:0] ea_mode = op_word[5:3];
  wire [2:0] ea_reg = op_word[2:0];
  wire fmt_small = ext_spec == fde_pkg::FMT_BYTE
    || ext_spec == fde_pkg::FMT_WORD || ext_spec == fde_pkg::FMT_LONG
    || ext_spec == fde_pkg::FMT_SINGLE;
  // address register direct (mode 001) falls through as illegal
  wire ea_ok = (ea_mode == 3'h0 && fmt_small)
    || (ea_mode >= 3'h2 && ea_mode <= 3'h6)
    || (ea_mode == 3'h7 && ea_reg <= 3'h4);
  // the ea field is not looked at for register sources
  wire src_ok = !ext_rm || (ea_ok && ext_spec != fde_pkg::FMT_BAD);
  wire legal = id_ok && (is_div || is_exp) && src_ok;
  // packed decimal conversion is not built in; it is flagged instead
  wire packed_src = ext_rm && ext_spec == fde_pkg::FMT_PACKED;

  // operand fetch and classification
  wire [79:0] src_ext = ext_rm ? to_ext(ext_spec, src_buf)
                               : fpr[ext_spec];
  wire [79:0] dst_ext = fpr[ext_dst];
  fde_pkg::fde_class_t sc;
  fde_pkg::fde_class_t dc;
  assign sc = classify(src_ext);
  assign dc = classify(dst_ext);
  wire res_sign = src_ext[79] ^ dst_ext[79];
  wire [79:0] inf_val = {res_sign, fde_pkg::EXP_MAX, fde_pkg::MANT_ONE};
  wire [79:0] zero_val = {res_sign, 79'h0};
  wire [79:0] dflt_nan = {1'b0, fde_pkg::EXP_MAX, fde_pkg::MANT_NAN};
  wire [79:0] nan_src = (dc == fde_pkg::CLS_NAN) ? dst_ext : src_ext;
  wire [79:0] quiet_nan = {nan_src[79:63], 1'b1, nan_src[61:0]};

  // divide special cases
  wire any_nan = sc == fde_pkg::CLS_NAN || dc == fde_pkg::CLS_NAN;
  wire div_invalid = (sc == fde_pkg::CLS_ZERO && dc == fde_pkg::CLS_ZERO)
    || (sc == fde_pkg::CLS_INF && dc == fde_pkg::CLS_INF);
  wire div_dz = sc == fde_pkg::CLS_ZERO && dc == fde_pkg::CLS_FIN;
  wire div_operand_error_flag = div_invalid;
  wire div_special = !(sc == fde_pkg::CLS_FIN && dc == fde_pkg::CLS_FIN);
  wire [79:0] div_res = any_nan ? quiet_nan
    : div_invalid ? dflt_nan
    : (div_dz || dc == fde_pkg::CLS_INF) ? inf_val
    : zero_val;

  // exponential: special operands resolved here, in-range is flagged
  wire src_fin = sc == fde_pkg::CLS_FIN;
  wire [79:0] exp_res = (sc == fde_pkg::CLS_NAN) ? quiet_nan
    : (sc == fde_pkg::CLS_ZERO) ? {1'b0, fde_pkg::EXP_BIAS, fde_pkg::MANT_ONE}
    : src_ext[79] ? 80'h0 : {1'b0, fde_pkg::EXP_MAX, fde_pkg::MANT_ONE};
  wire exec_ok = start && legal && !packed_src;
  wire quick_wr = exec_ok && ((is_div && div_special)
    || (is_exp && !src_fin));
  wire div_go = exec_ok && is_div && !div_special;

  // divider datapath
  wire [64:0] rem_sub = rem - {1'b0, divisor};
  wire rem_ge = rem >= {1'b0, divisor};
  wire [64:0] quo_next = {quo[63:0], rem_ge};
  wire signed [17:0] exp_start = $signed({3'h0, dst_ext[78:64]})
    - $signed({3'h0, src_ext[78:64]}) + $signed({3'h0, fde_pkg::EXP_BIAS});
  wire signed [17:0] wb_exp = quo[64] ? q_exp : q_exp - 18'sh0_0001;
  wire [63:0] wb_mant = quo[64] ? quo[64:1] : quo[63:0];
  // no rounding: the quotient is truncated; range errors clamp
  wire [79:0] wb_val = (wb_exp >= $signed({3'h0, fde_pkg::EXP_MAX}))
    ? {q_sign, fde_pkg::EXP_MAX, fde_pkg::MANT_ONE}
    : (wb_exp <= 18'sh0_0000) ? {q_sign, 79'h0}
    : {q_sign, wb_exp[14:0], wb_mant};
  wire in_wb = state == fde_pkg::ST_WB;

  // result write port
  wire res_we = quick_wr || in_wb;
  wire [2:0] res_idx = in_wb ? q_dst : ext_dst;
  wire [79:0] res_val = in_wb ? wb_val : (is_div ? div_res : exp_res);

  // exception byte and interrupt events
  wire [7:0] exc_div = ({7'h00, div_dz} << fde_pkg::EXC_DIVIDE_BY_ZERO)
    | ({7'h00, div_operand_error_flag} << fde_pkg::EXC_OPERAND_ERROR);
  wire ev_dz = quick_wr && is_div && div_dz;
  wire ev_operand_error_flag = quick_wr && is_div && div_operand_error_flag;
  wire ev_reject = start && !legal;
  wire ev_unsup = exec_ok && is_exp && src_fin || start && legal && packed_src;
  wire [fde_pkg::INT_W-1:0] ev = {ev_unsup, ev_reject, ev_operand_error_flag, ev_dz,
                                  res_we};
  wire [fde_pkg::INT_W-1:0] int_clr = wr_int_st
    ? wdata[fde_pkg::INT_W-1:0] : '0;
  // set wins over a same-cycle clear
  wire [fde_pkg::INT_W-1:0] next_int_status = (int_status & ~int_clr) | ev;

  // read mux
  wire [79:0] sel_reg = fpr[reg_sel];
  wire [31:0] next_rdata = !rd_en ? 32'h0000_0000
    : addr == fde_pkg::ADDR_CTRL ? {29'h0, own_id}
    : addr == fde_pkg::ADDR_OPWORD ? {16'h0000, op_word}
    : addr == fde_pkg::ADDR_SRC_LO ? src_buf[31:0]
    : addr == fde_pkg::ADDR_SRC_MID ? src_buf[63:32]
    : addr == fde_pkg::ADDR_SRC_HI ? {16'h0000, src_buf[79:64]}
    : addr == fde_pkg::ADDR_STATUS ? {23'h0, !idle, exc}
    : addr == fde_pkg::ADDR_INT_STATUS ? {27'h0, int_status}
    : addr == fde_pkg::ADDR_INT_MASK ? {27'h0, int_mask}
    : addr == fde_pkg::ADDR_REG_SEL ? {29'h0, reg_sel}
    : addr == fde_pkg::ADDR_REG_LO ? sel_reg[31:0]
    : addr == fde_pkg::ADDR_REG_MID ? sel_reg[63:32]
    : addr == fde_pkg::ADDR_REG_HI ? {16'h0000, sel_reg[79:64]}
    : 32'h0000_0000;

  // state machine
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state <= fde_pkg::ST_IDLE;
      cnt <= 7'h00;
    end else begin
      unique case (state)
        fde_pkg::ST_IDLE: begin
          cnt <= 7'h00;
          if (div_go) begin
            state <= fde_pkg::ST_DIV;
          end
        end
        fde_pkg::ST_DIV: begin
          cnt <= cnt + 7'h01;
          if (cnt == fde_pkg::DIV_STEPS - 7'h01) begin
            state <= fde_pkg::ST_WB;
          end
        end
        fde_pkg::ST_WB: state <= fde_pkg::ST_IDLE;
      endcase
    end
  end

  // restoring mantissa divide, one quotient bit per cycle
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rem <= '0;
      divisor <= '0;
      quo <= '0;
      q_sign <= 1'b0;
      q_exp <= '0;
      q_dst <= 3'h0;
    end else if (div_go) begin
      rem <= {1'b0, dst_ext[63:0]};
      divisor <= src_ext[63:0];
      quo <= '0;
      q_sign <= res_sign;
      q_exp <= exp_start;
      q_dst <= ext_dst;
    end else if (state == fde_pkg::ST_DIV) begin
      rem <= (rem_ge ? rem_sub : rem) << 1;
      quo <= quo_next;
    end
  end

  // float data registers; the write-back port has priority over the bus
  always_ff @(posedge clk) begin
    if (res_we) begin
      fpr[res_idx] <= res_val;
    end else if (wr_reg_lo) begin
      fpr[reg_sel][31:0] <= wdata;
    end else if (wr_reg_mid) begin
      fpr[reg_sel][63:32] <= wdata;
    end else if (wr_reg_hi) begin
      fpr[reg_sel][79:64] <= wdata[15:0];
    end
  end

  // software-visible control registers
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      own_id <= OWN_ID_RESET;
      op_word <= 16'h0000;
      src_buf <= '0;
      reg_sel <= 3'h0;
      int_mask <= fde_pkg::INT_MASK_RESET;
    end else begin
      if (wr_ctrl) own_id <= wdata[2:0];
      if (wr_op) op_word <= wdata[15:0];
      if (wr_src_lo) src_buf[31:0] <= wdata;
      if (wr_src_mid) src_buf[63:32] <= wdata;
      if (wr_src_hi) src_buf[79:64] <= wdata[15:0];
      if (wr_reg_sel) reg_sel <= wdata[2:0];
      if (wr_int_mask) int_mask <= wdata[fde_pkg::INT_W-1:0];
    end
  end

  // exception byte: every finished divide rewrites both flags
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      exc <= fde_pkg::EXC_RESET;
    end else if (quick_wr) begin
      exc <= is_div ? exc_div : 8'h00;
    end else if (in_wb) begin
      exc <= 8'h00;
    end
  end

  // interrupt and read-data outputs
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      int_status <= '0;
      irq <= 1'b0;
      rdata <= 32'h0000_0000;
    end else begin
      int_status <= next_int_status;
      irq <= |(next_int_status & int_mask);
      rdata <= next_rdata;
    end
  end
endmodule

// *** src/fde_pkg.sv ***
// shared constants and types for the float divide / exponential decoder
package fde_pkg;
  // register byte addresses
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_OPWORD = 8'h04;
  localparam logic [7:0] ADDR_EXTWORD = 8'h08;
  localparam logic [7:0] ADDR_SRC_LO = 8'h0c;
  localparam logic [7:0] ADDR_SRC_MID = 8'h10;
  localparam logic [7:0] ADDR_SRC_HI = 8'h14;
  localparam logic [7:0] ADDR_STATUS = 8'h18;
  localparam logic [7:0] ADDR_INT_STATUS = 8'h1c;
  localparam logic [7:0] ADDR_INT_MASK = 8'h20;
  localparam logic [7:0] ADDR_REG_SEL = 8'h24;
  localparam logic [7:0] ADDR_REG_LO = 8'h28;
  localparam logic [7:0] ADDR_REG_MID = 8'h2c;
  localparam logic [7:0] ADDR_REG_HI = 8'h30;
  // operation word fields
  localparam int OP_ID_HI = 11;
  localparam int OP_ID_LO = 9;
  localparam logic [3:0] OP_PREFIX = 4'hf;
  // extension word fields
  localparam int EXT_TOP_BIT = 15;
  localparam int EXT_RM_BIT = 14;
  localparam int EXT_ZERO_BIT = 13;
  localparam logic [6:0] OPMODE_DIVIDE = 7'h20;
  localparam logic [6:0] OPMODE_EXP = 7'h10;
  // status exception byte bit positions
  localparam int EXC_OPERAND_ERROR = 5;
  localparam int EXC_DIVIDE_BY_ZERO = 2;
  // interrupt status / mask bits
  localparam int INT_DONE = 0;
  localparam int INT_DZ = 1;
  localparam int INT_OPERAND_ERROR_FLAG = 2;
  localparam int INT_REJECT = 3;
  localparam int INT_UNSUP = 4;
  localparam int INT_W = 5;
  // reset values
  localparam logic [4:0] INT_MASK_RESET = 5'h00;
  localparam logic [7:0] EXC_RESET = 8'h00;
  // extended-precision constants
  localparam logic [14:0] EXP_MAX = 15'h7fff;
  localparam logic [14:0] EXP_BIAS = 15'h3fff;
  localparam logic [14:0] SGL_ADJ = 15'h3f80;
  localparam logic [14:0] DBL_ADJ = 15'h3c00;
  localparam logic [14:0] INT_EXP_TOP = 15'h401e;
  localparam logic [63:0] MANT_ONE = 64'h8000_0000_0000_0000;
  localparam logic [63:0] MANT_NAN = 64'hffff_ffff_ffff_ffff;
  localparam logic [6:0] DIV_STEPS = 7'h41;
  typedef enum logic [2:0] {
    FMT_LONG = 3'h0, FMT_SINGLE = 3'h1, FMT_EXTENDED = 3'h2,
    FMT_PACKED = 3'h3, FMT_WORD = 3'h4, FMT_DOUBLE = 3'h5,
    FMT_BYTE = 3'h6, FMT_BAD = 3'h7
  } fde_fmt_t;
  typedef enum logic [1:0] {
    CLS_FIN = 2'h0, CLS_ZERO = 2'h1, CLS_INF = 2'h2, CLS_NAN = 2'h3
  } fde_class_t;
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00, ST_DIV = 2'b01, ST_WB = 2'b11
  } fde_state_t;
endpackage

// *** sim/fde_core_sva.sv ***
// assertions on the register port of the divide / exponential decoder
`timescale 1ns/1ns
module fde_core_sva #(
  parameter logic [2:0] OWN_ID_RESET = 3'h1
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [7:0] addr,
  input wire logic [31:0] wdata,
  input wire logic wr_en,
  input wire logic rd_en,
  input wire logic [31:0] rdata,
  input wire logic irq
);
  logic [4:0] mask_sh;
  logic [2:0] id_sh;
  wire logic mask_wr = wr_en && addr == fde_pkg::ADDR_INT_MASK;
  wire logic id_wr = wr_en && addr == fde_pkg::ADDR_CTRL;
  wire logic stat_rd = rd_en && addr == fde_pkg::ADDR_STATUS;
  wire logic bad_rd = rd_en && (addr > 8'h30 || addr[1:0] != 2'h0);
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      mask_sh <= fde_pkg::INT_MASK_RESET;
      id_sh <= OWN_ID_RESET;
    end else begin
      if (mask_wr) begin
        mask_sh <= wdata[4:0];
      end
      if (id_wr) begin
        id_sh <= wdata[2:0];
      end
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  // mask cleared, then left alone for a cycle
  sequence s_mask_off;
    mask_wr && wdata[4:0] == 5'h00 ##1 !mask_wr;
  endsequence
  a_exc_reserved: assert property (
    stat_rd |=> (rdata & 32'hffff_fedb) == 32'h0000_0000)
    else $error("reserved status bits set");
  a_flags_exclusive: assert property (
    stat_rd |=> !(rdata[5] && rdata[2]))
    else $error("both exception flags set");
  a_rdata_idle: assert property (!rd_en |=> rdata == 32'h0000_0000)
    else $error("read data outside its cycle");
  a_unmapped_zero: assert property (bad_rd |=> rdata == 32'h0000_0000)
    else $error("unmapped read not zero");
  a_id_readback: assert property (
    rd_en && addr == fde_pkg::ADDR_CTRL |=> rdata[2:0] == id_sh)
    else $error("identity readback wrong");
  a_mask_readback: assert property (
    rd_en && addr == fde_pkg::ADDR_INT_MASK |=> rdata[4:0] == mask_sh)
    else $error("mask readback wrong");
  a_irq_needs_mask: assert property (irq |-> $past(mask_sh) != 5'h00)
    else $error("irq with all sources masked");
  a_irq_masked_off: assert property (s_mask_off |=> !irq)
    else $error("irq stays after mask cleared");
endmodule
bind fde_core fde_core_sva #(.OWN_ID_RESET(OWN_ID_RESET)) i_fde_core_sva (
  .clk(clk), .rst(rst), .addr(addr), .wdata(wdata), .wr_en(wr_en),
  .rd_en(rd_en), .rdata(rdata), .irq(irq));

// *** sim/fde_host.sv ***
// host processor model issuing instructions over the register port
`timescale 1ns/1ns
module fde_host (
  input wire logic clk,
  input wire logic [31:0] rdata,
  output logic [7:0] addr,
  output logic [31:0] wdata,
  output logic wr_en,
  output logic rd_en
);
  initial begin
    addr = 8'h00;
    wdata = 32'h0000_0000;
    wr_en = 1'b0;
    rd_en = 1'b0;
  end
  task automatic wr(input logic [7:0] a, input logic [31:0] x);
    addr <= a;
    wdata <= x;
    wr_en <= 1'b1;
    @(posedge clk);
    wr_en <= 1'b0;
    @(posedge clk);
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] x);
    addr <= a;
    rd_en <= 1'b1;
    @(posedge clk);
    rd_en <= 1'b0;
    // read data stand until this edge; taken before it is overwritten
    @(posedge clk);
    x = rdata;
  endtask
  // the extension word write starts execution, so it goes last
  task automatic issue(input logic [2:0] id, input logic rm,
    input logic [2:0] sp, input logic [2:0] dr, input logic [5:0] ea,
    input logic [6:0] om);
    wr(fde_pkg::ADDR_OPWORD,
      {16'h0000, 4'hf, id, 3'h0, rm ? ea : 6'h00});
    wr(fde_pkg::ADDR_EXTWORD,
      {16'h0000, 1'b0, rm, 1'b0, sp, dr, om});
  endtask
endmodule

// *** sim/fde_core_test.sv ***
// self-checking bench for the float divide / exponential decoder
`timescale 1ns/1ns
module fde_core_test;
  localparam logic [79:0] PZERO = 80'h0000_0000_0000_0000_0000;
  localparam logic [79:0] MZERO = 80'h8000_0000_0000_0000_0000;
  localparam logic [79:0] PONE = 80'h3fff_8000_0000_0000_0000;
  localparam logic [79:0] MONE = 80'hbfff_8000_0000_0000_0000;
  // infinities are written back with the integer bit set
  localparam logic [79:0] PINF = 80'h7fff_8000_0000_0000_0000;
  localparam logic [79:0] MINF = 80'hffff_8000_0000_0000_0000;
  localparam logic [79:0] DNAN = 80'h7fff_ffff_ffff_ffff_ffff;
  localparam logic [79:0] SIX = 80'h4001_c000_0000_0000_0000;
  localparam logic [79:0] TWO = 80'h4000_8000_0000_0000_0000;
  localparam logic [79:0] THREE = 80'h4000_c000_0000_0000_0000;
  localparam logic [6:0] DIV = fde_pkg::OPMODE_DIVIDE;
  localparam logic [6:0] EXP = fde_pkg::OPMODE_EXP;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [7:0] addr;
  logic [31:0] wdata;
  logic [31:0] rdata;
  logic wr_en;
  logic rd_en;
  logic irq;
  int num_errors = 0;
  int check_count = 0;
  logic [4:0] imask = 5'h1f;
  logic [4:0] mk = 5'h00;
  logic [31:0] d;
  logic [79:0] v;
  // last three rows are exponentials of special operands
  logic [79:0] dv [12] = '{SIX, PONE, MONE, PZERO, PINF, MONE, PZERO, PINF,
    MZERO, MONE, MONE, MONE};
  logic [79:0] sv [12] = '{TWO, PZERO, PZERO, PZERO, MINF, PINF, MONE, MONE,
    MZERO, PZERO, MINF, PINF};
  logic [79:0] rv [12] = '{THREE, PINF, MINF, DNAN, DNAN, MZERO, MZERO,
    MINF, DNAN, PONE, PZERO, PINF};
  logic [7:0] ev [12] = '{8'h00, 8'h04, 8'h04, 8'h20, 8'h20, 8'h00, 8'h00,
    8'h00, 8'h20, 8'h00, 8'h00, 8'h00};
  logic [7:0] ra [7] = '{fde_pkg::ADDR_CTRL, fde_pkg::ADDR_STATUS,
    fde_pkg::ADDR_INT_STATUS, fde_pkg::ADDR_INT_MASK, fde_pkg::ADDR_REG_SEL,
    8'h34, 8'h02};
  always #20 clk = ~clk;
  fde_core i_fde_core (.clk(clk), .rst(rst), .addr(addr), .wdata(wdata),
    .wr_en(wr_en), .rd_en(rd_en), .rdata(rdata), .irq(irq));
  fde_host i_fde_host (.clk(clk), .rdata(rdata), .addr(addr),
    .wdata(wdata), .wr_en(wr_en), .rd_en(rd_en));
  task automatic chk(input string n, input logic [79:0] s,
    input logic [79:0] e);
    check_count++;
    if (s !== e) begin
      num_errors++;
      $display("[FAIL] %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic finish_test();
    if (num_errors == 0 && check_count > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  task automatic set_mask(input logic [4:0] m);
    mk = m;
    i_fde_host.wr(fde_pkg::ADDR_INT_MASK, 32'(m));
  endtask
  task automatic put_fp(input logic [2:0] n, input logic [79:0] x);
    i_fde_host.wr(fde_pkg::ADDR_REG_SEL, 32'(n));
    i_fde_host.wr(fde_pkg::ADDR_REG_LO, x[31:0]);
    i_fde_host.wr(fde_pkg::ADDR_REG_MID, x[63:32]);
    i_fde_host.wr(fde_pkg::ADDR_REG_HI, 32'(x[79:64]));
  endtask
  task automatic get_fp(input logic [2:0] n, output logic [79:0] x);
    logic [31:0] a;
    logic [31:0] b;
    logic [31:0] c;
    i_fde_host.wr(fde_pkg::ADDR_REG_SEL, 32'(n));
    i_fde_host.rd(fde_pkg::ADDR_REG_LO, a);
    i_fde_host.rd(fde_pkg::ADDR_REG_MID, b);
    i_fde_host.rd(fde_pkg::ADDR_REG_HI, c);
    x = {c[15:0], b, a};
  endtask
  // issue, poll events (bounded), check irq, then clear and recheck
  task automatic go(input logic [2:0] id, input logic rm,
    input logic [2:0] sp, input logic [2:0] dr, input logic [5:0] ea,
    input logic [6:0] om, input logic [4:0] ei);
    int n;
    i_fde_host.issue(id, rm, sp, dr, ea, om);
    d = 32'h0000_0000;
    n = 0;
    while (d[4:0] == 5'h00 && n < 80) begin
      i_fde_host.rd(fde_pkg::ADDR_INT_STATUS, d);
      n++;
    end
    chk("int_status", 80'(d[4:0] & imask), 80'(ei));
    chk("irq", 80'(irq), 80'(|(d[4:0] & mk)));
    i_fde_host.wr(fde_pkg::ADDR_INT_STATUS, 32'h0000_001f);
    i_fde_host.rd(fde_pkg::ADDR_INT_STATUS, d);
    chk("irq_clear", 80'(irq), 80'h0);
  endtask
  initial begin
    repeat (20000) @(posedge clk);
    num_errors++;
    finish_test();
  end
  initial begin
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    i_fde_host.wr(8'h34, 32'hffff_ffff);
    i_fde_host.wr(8'h02, 32'hffff_ffff);
    i_fde_host.wr(fde_pkg::ADDR_STATUS, 32'hffff_ffff);
    for (int i = 0; i < 7; i++) begin
      i_fde_host.rd(ra[i], d);
      chk("reset_value", 80'(d), 80'(i == 0));
    end
    set_mask(5'h02);
    for (int i = 0; i < 12; i++) begin
      put_fp(3'(i % 7), dv[i]);
      put_fp(3'h7, sv[i]);
      go(3'h1, 1'b0, 3'h7, 3'(i % 7), 6'h3f, i > 8 ? EXP : DIV,
        {2'b00, ev[i][5], ev[i][2], 1'b1});
      i_fde_host.rd(fde_pkg::ADDR_STATUS, d);
      chk("exc_byte", 80'(d[8:0]), 80'(ev[i]));
      get_fp(3'(i % 7), v);
      chk("result", v, rv[i]);
    end
    set_mask(5'h06);
    imask = 5'h1e;
    for (int o = 0; o < 2; o++) begin
      for (int s = 0; s < 8; s++) begin
        put_fp(3'h1, MONE);
        go(3'h1, 1'b1, 3'(s), 3'h1, 6'h3c, o ? EXP : DIV, s == 3 ? 5'h10 :
          s == 7 ? 5'h08 : o ? 5'h00 : 5'h02);
        get_fp(3'h1, v);
        chk("format_result", v, (s == 3 || s == 7) ? MONE :
          o ? PONE : MINF);
      end
    end
    for (int e = 0; e < 64; e++) begin
      put_fp(3'h2, MONE);
      go(3'h1, 1'b1, 3'h0, 3'h2, 6'(e), DIV, (e / 8 == 1 || e > 60) ?
        5'h08 : 5'h02);
    end
    go(3'h1, 1'b1, 3'h2, 3'h2, 6'h00, DIV, 5'h08);
    go(3'h1, 1'b0, 3'h4, 3'h2, 6'h00, 7'h21, 5'h08);
    // nonzero memory sources: single 2.0, then long -2
    i_fde_host.wr(fde_pkg::ADDR_SRC_LO, 32'h4000_0000);
    put_fp(3'h3, SIX);
    go(3'h1, 1'b1, 3'h1, 3'h3, 6'h3c, DIV, 5'h00);
    get_fp(3'h3, v);
    chk("single_source", v, THREE);
    i_fde_host.wr(fde_pkg::ADDR_SRC_LO, 32'hffff_fffe);
    put_fp(3'h3, SIX);
    go(3'h1, 1'b1, 3'h0, 3'h3, 6'h3c, DIV, 5'h00);
    get_fp(3'h3, v);
    chk("long_source", v, 80'hc000_c000_0000_0000_0000);
    imask = 5'h01;
    put_fp(3'h4, PZERO);
    put_fp(3'h2, PONE);
    go(3'h2, 1'b0, 3'h4, 3'h2, 6'h00, DIV, 5'h00);
    get_fp(3'h2, v);
    chk("foreign_id", v, PONE);
    i_fde_host.wr(fde_pkg::ADDR_CTRL, 32'h0000_0002);
    go(3'h2, 1'b0, 3'h4, 3'h2, 6'h00, DIV, 5'h01);
    get_fp(3'h2, v);
    chk("own_id", v, PINF);
    set_mask(5'h00);
    repeat (3) @(posedge clk);
    finish_test();
  end
endmodule
